//--- crt_cursor_vertical_timing.sv
// module: text cursor, display addressing and vertical timing of the crt controller
// Notes on behaviour
// - cursor start field is first line minus one
// - start above end means no cursor
// - cursor disable bit one suppresses cursor
// - cursor end field is last cursor line
// - skew delays cursor zero to three characters
// - start address loaded after each vertical retrace
// - cursor shown where address equals cursor location
// - enhanced mode reuses location bytes as colours
// - vsync begins at ten-bit start line
// - vsync ends when low nibble matches end
// - interrupt flop set at end of display
// - clear bit zero holds interrupt flop cleared
// - disable bit one blocks vertical interrupt
// - refresh select gives three or five cycles
// - protect bit locks timing indices zero to seven
// - display ends at ten-bit last line value
// - next row start adds k times pitch
// - underline on field plus one line
// - step four and doubleword set address mode
// - vblank begins one after ten-bit start
// - vblank ends when line matches eight-bit end
// - row scan counts per retrace, clears at max
// - overflow bits two and seven extend vsync
`timescale 1ns/1ps
`default_nettype none

module crt_cursor_vertical_timing (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic index_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wdata,
  input wire logic char_clk_en,
  input wire logic hretrace_start,
  input wire logic hdisplay,
  input wire crt_vert_pkg::ext_timing_type ext_timing,
  input wire crt_vert_pkg::ext_mode_type ext_mode,
  output logic [7:0] rdata,
  output logic timing_write_protect,
  output logic vsync,
  output logic vblank,
  output logic vint,
  output logic text_cursor,
  output logic underline,
  output logic [15:0] mem_addr,
  output logic refresh_req,
  output logic [7:0] hw_cursor_fg,
  output logic [7:0] hw_cursor_bg,
  output logic addr_step_four,
  output logic doubleword_addressing
);

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_r;
  logic rst_sync_n_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indexed register file
  logic [7:0] index_r;
  logic [7:0] cursor_first_row_r;
  logic [7:0] cursor_last_row_r;
  logic [7:0] display_origin_hi_r;
  logic [7:0] display_origin_lo_r;
  logic [7:0] cursor_addr_hi_r;
  logic [7:0] cursor_addr_lo_r;
  logic [7:0] vsync_begin_r;
  logic [7:0] vsync_end_control_r;
  logic [7:0] vdisplay_last_line_r;
  logic [7:0] row_pitch_r;
  logic [7:0] underline_and_addr_mode_r;
  logic [7:0] vblank_begin_r;
  logic [7:0] vblank_finish_r;
  logic [7:0] rdata_nxt;

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      index_r <= crt_vert_pkg::REG_RESET;
    end else if (index_wr) begin
      index_r <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      cursor_first_row_r <= crt_vert_pkg::REG_RESET;
      cursor_last_row_r <= crt_vert_pkg::REG_RESET;
      display_origin_hi_r <= crt_vert_pkg::REG_RESET;
      display_origin_lo_r <= crt_vert_pkg::REG_RESET;
      cursor_addr_hi_r <= crt_vert_pkg::REG_RESET;
      cursor_addr_lo_r <= crt_vert_pkg::REG_RESET;
      vsync_begin_r <= crt_vert_pkg::REG_RESET;
      vsync_end_control_r <= crt_vert_pkg::REG_RESET;
      vdisplay_last_line_r <= crt_vert_pkg::REG_RESET;
      row_pitch_r <= crt_vert_pkg::REG_RESET;
      underline_and_addr_mode_r <= crt_vert_pkg::REG_RESET;
      vblank_begin_r <= crt_vert_pkg::REG_RESET;
      vblank_finish_r <= crt_vert_pkg::REG_RESET;
    end else if (data_wr) begin
      unique case (index_r)
        crt_vert_pkg::IDX_CURSOR_FIRST_ROW:
          cursor_first_row_r <= wdata & crt_vert_pkg::MASK_CURSOR_FIRST_ROW;
        crt_vert_pkg::IDX_CURSOR_LAST_ROW:
          cursor_last_row_r <= wdata & crt_vert_pkg::MASK_CURSOR_LAST_ROW;
        crt_vert_pkg::IDX_DISPLAY_ORIGIN_HI: display_origin_hi_r <= wdata;
        crt_vert_pkg::IDX_DISPLAY_ORIGIN_LO: display_origin_lo_r <= wdata;
        crt_vert_pkg::IDX_CURSOR_ADDR_HI: cursor_addr_hi_r <= wdata;
        crt_vert_pkg::IDX_CURSOR_ADDR_LO: cursor_addr_lo_r <= wdata;
        crt_vert_pkg::IDX_VSYNC_BEGIN: vsync_begin_r <= wdata;
        crt_vert_pkg::IDX_VSYNC_END_CONTROL: vsync_end_control_r <= wdata;
        crt_vert_pkg::IDX_VDISPLAY_LAST_LINE: vdisplay_last_line_r <= wdata;
        crt_vert_pkg::IDX_ROW_PITCH: row_pitch_r <= wdata;
        crt_vert_pkg::IDX_UNDERLINE_AND_ADDR_MODE:
          underline_and_addr_mode_r <= wdata & crt_vert_pkg::MASK_UNDERLINE_AND_ADDR_MODE;
        crt_vert_pkg::IDX_VBLANK_BEGIN: vblank_begin_r <= wdata;
        crt_vert_pkg::IDX_VBLANK_FINISH: vblank_finish_r <= wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (index_r)
      crt_vert_pkg::IDX_CURSOR_FIRST_ROW: rdata_nxt = cursor_first_row_r;
      crt_vert_pkg::IDX_CURSOR_LAST_ROW: rdata_nxt = cursor_last_row_r;
      crt_vert_pkg::IDX_DISPLAY_ORIGIN_HI: rdata_nxt = display_origin_hi_r;
      crt_vert_pkg::IDX_DISPLAY_ORIGIN_LO: rdata_nxt = display_origin_lo_r;
      crt_vert_pkg::IDX_CURSOR_ADDR_HI: rdata_nxt = cursor_addr_hi_r;
      crt_vert_pkg::IDX_CURSOR_ADDR_LO: rdata_nxt = cursor_addr_lo_r;
      crt_vert_pkg::IDX_VSYNC_BEGIN: rdata_nxt = vsync_begin_r;
      crt_vert_pkg::IDX_VSYNC_END_CONTROL: rdata_nxt = vsync_end_control_r;
      crt_vert_pkg::IDX_VDISPLAY_LAST_LINE: rdata_nxt = vdisplay_last_line_r;
      crt_vert_pkg::IDX_ROW_PITCH: rdata_nxt = row_pitch_r;
      crt_vert_pkg::IDX_UNDERLINE_AND_ADDR_MODE: rdata_nxt = underline_and_addr_mode_r;
      crt_vert_pkg::IDX_VBLANK_BEGIN: rdata_nxt = vblank_begin_r;
      crt_vert_pkg::IDX_VBLANK_FINISH: rdata_nxt = vblank_finish_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      rdata <= 8'h00;
    end else if (data_rd) begin
      rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control decode and registered control outputs
  logic [9:0] vtotal;
  logic [9:0] vsync_start;
  logic [9:0] vdisp_end;
  logic [9:0] vblank_start;
  logic [4:0] max_scan;
  logic vint_clear_n;
  logic vint_disable;
  logic refresh_five;

  assign vtotal = {ext_timing.overflow[crt_vert_pkg::OVF_VT9],
                   ext_timing.overflow[crt_vert_pkg::OVF_VT8], ext_timing.vtotal_lo};
  assign vsync_start = {ext_timing.overflow[crt_vert_pkg::OVF_VRS9],
                        ext_timing.overflow[crt_vert_pkg::OVF_VRS8], vsync_begin_r};
  assign vdisp_end = {ext_timing.overflow[crt_vert_pkg::OVF_VDE9],
                      ext_timing.overflow[crt_vert_pkg::OVF_VDE8], vdisplay_last_line_r};
  assign vblank_start = {ext_timing.max_scan_line[crt_vert_pkg::MSL_SVB9],
                         ext_timing.overflow[crt_vert_pkg::OVF_SVB8], vblank_begin_r};
  assign max_scan = ext_timing.max_scan_line[crt_vert_pkg::ROW_FIELD_MSB:0];
  assign vint_clear_n = vsync_end_control_r[crt_vert_pkg::BIT_VINT_CLEAR_N];
  assign vint_disable = vsync_end_control_r[crt_vert_pkg::BIT_VINT_DISABLE];
  assign refresh_five = vsync_end_control_r[crt_vert_pkg::BIT_REFRESH_FIVE];

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      timing_write_protect <= 1'b0;
      hw_cursor_fg <= 8'h00;
      hw_cursor_bg <= 8'h00;
      addr_step_four <= 1'b0;
      doubleword_addressing <= 1'b0;
    end else begin
      // the outside timing registers honour this, overflow bit 4 excepted
      timing_write_protect <= vsync_end_control_r[crt_vert_pkg::BIT_TIMING_WRITE_PROTECT];
      hw_cursor_fg <= ext_mode.enhanced ? cursor_addr_hi_r : 8'h00;
      hw_cursor_bg <= ext_mode.enhanced ? cursor_addr_lo_r : 8'h00;
      addr_step_four <= underline_and_addr_mode_r[crt_vert_pkg::BIT_ADDR_STEP_FOUR];
      doubleword_addressing <= underline_and_addr_mode_r[crt_vert_pkg::BIT_DOUBLEWORD_ADDRESSING];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line and row scan counters
  logic [9:0] vline_r;
  logic [4:0] row_scan_r;
  logic frame_wrap;

  assign frame_wrap = (vline_r == 10'(vtotal + 10'h001));

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      vline_r <= 10'h000;
      row_scan_r <= 5'h00;
    end else if (hretrace_start) begin
      vline_r <= frame_wrap ? 10'h000 : 10'(vline_r + 10'h001);
      if (frame_wrap || row_scan_r == max_scan) begin
        row_scan_r <= 5'h00;
      end else begin
        row_scan_r <= 5'(row_scan_r + 5'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vertical sync, blank and interrupt
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      vsync <= 1'b0;
    end else if (vline_r == vsync_start) begin
      vsync <= 1'b1;
    end else if (vline_r[3:0] == vsync_end_control_r[3:0]) begin
      vsync <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      vblank <= 1'b0;
    end else if (vline_r == 10'(vblank_start + 10'h001)) begin
      vblank <= 1'b1;
    end else if (vline_r[7:0] == vblank_finish_r) begin
      vblank <= 1'b0;
    end
  end

  // host pulses the clear bit low then high to rearm
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      vint <= 1'b0;
    end else if (!vint_clear_n) begin
      vint <= 1'b0;
    end else if (!vint_disable && vline_r == 10'(vdisp_end + 10'h001)) begin
      vint <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display addressing
  logic [15:0] row_start_r;
  logic [1:0] step_cnt_r;
  logic [1:0] step_last;
  logic [10:0] pitch_bytes;
  logic row_end;
  logic [15:0] row_next;

  always_comb begin
    if (underline_and_addr_mode_r[crt_vert_pkg::BIT_ADDR_STEP_FOUR]) begin
      step_last = 2'h3;
    end else if (ext_mode.count_by_two) begin
      step_last = 2'h1;
    end else begin
      step_last = 2'h0;
    end
    if (underline_and_addr_mode_r[crt_vert_pkg::BIT_DOUBLEWORD_ADDRESSING]) begin
      pitch_bytes = {row_pitch_r, 3'h0};
    end else if (ext_mode.count_by_two) begin
      pitch_bytes = {1'b0, row_pitch_r, 2'h0};
    end else begin
      pitch_bytes = {2'h0, row_pitch_r, 1'b0};
    end
  end

  assign row_end = hretrace_start && (row_scan_r == max_scan);
  assign row_next = 16'(row_start_r + {5'h00, pitch_bytes});

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      row_start_r <= 16'h0000;
    end else if (hretrace_start && frame_wrap) begin
      row_start_r <= {display_origin_hi_r, display_origin_lo_r};
    end else if (row_end) begin
      row_start_r <= row_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      mem_addr <= 16'h0000;
      step_cnt_r <= 2'h0;
    end else if (hretrace_start) begin
      // first line of a new row already uses the advanced row start
      if (frame_wrap) begin
        mem_addr <= {display_origin_hi_r, display_origin_lo_r};
      end else begin
        mem_addr <= row_end ? row_next : row_start_r;
      end
      step_cnt_r <= 2'h0;
    end else if (char_clk_en && hdisplay) begin
      if (step_cnt_r == step_last) begin
        step_cnt_r <= 2'h0;
        mem_addr <= 16'(mem_addr + 16'h0001);
      end else begin
        step_cnt_r <= 2'(step_cnt_r + 2'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // text cursor and underline
  logic [4:0] cursor_start;
  logic [4:0] cursor_end;
  logic cursor_lines_ok;
  logic cursor_raw;
  logic [3:0] cursor_dly_r;
  logic [1:0] cursor_delay;

  assign cursor_start = cursor_first_row_r[crt_vert_pkg::ROW_FIELD_MSB:0];
  assign cursor_end = cursor_last_row_r[crt_vert_pkg::ROW_FIELD_MSB:0];
  assign cursor_delay = cursor_last_row_r[crt_vert_pkg::BIT_CURSOR_DELAY_LSB +: 2];
  assign cursor_lines_ok = (cursor_start <= cursor_end)
    && ({1'b0, row_scan_r} >= 6'({1'b0, cursor_start} + 6'h01))
    && (row_scan_r <= cursor_end);
  assign cursor_raw = hdisplay && cursor_lines_ok
    && !cursor_first_row_r[crt_vert_pkg::BIT_TEXT_CURSOR_DISABLE]
    && (mem_addr == {cursor_addr_hi_r, cursor_addr_lo_r});

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      cursor_dly_r <= 4'h0;
      text_cursor <= 1'b0;
    end else begin
      if (char_clk_en) begin
        cursor_dly_r <= {cursor_dly_r[2:0], cursor_raw};
      end
      text_cursor <= cursor_dly_r[cursor_delay];
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      underline <= 1'b0;
    end else begin
      underline <= ({1'b0, row_scan_r} ==
        6'({1'b0, underline_and_addr_mode_r[crt_vert_pkg::ROW_FIELD_MSB:0]} + 6'h01));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refresh cycles during horizontal blank
  logic [2:0] refresh_left_r;
  logic [2:0] refresh_seen_r;
  logic refresh_five_line_r;

  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      refresh_left_r <= 3'h0;
      refresh_req <= 1'b0;
      refresh_five_line_r <= 1'b0;
    end else if (hretrace_start) begin
      // select as latched at line start, so a mid-line change is harmless
      refresh_five_line_r <= refresh_five;
      refresh_left_r <= refresh_five ? crt_vert_pkg::REFRESH_FIVE
                                     : crt_vert_pkg::REFRESH_THREE;
      refresh_req <= 1'b0;
    end else begin
      refresh_req <= char_clk_en && !hdisplay && (refresh_left_r != 3'h0);
      if (char_clk_en && !hdisplay && refresh_left_r != 3'h0) begin
        refresh_left_r <= 3'(refresh_left_r - 3'h1);
      end
    end
  end

  // helper: refresh pulses counted since the last line start
  always_ff @(posedge core_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      refresh_seen_r <= 3'h0;
    end else if (hretrace_start) begin
      refresh_seen_r <= 3'h0;
    end else if (refresh_req && refresh_seen_r != 3'h7) begin
      refresh_seen_r <= 3'(refresh_seen_r + 3'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n_r);

  chk_vsync_start: assert property ($rose(vsync) |-> $past(vline_r) == $past(vsync_start))
    else $error("vsync rose away from start line");
  chk_vsync_end: assert property ($fell(vsync) |->
    $past(vline_r[3:0]) == $past(vsync_end_control_r[3:0]))
    else $error("vsync fell without end match");
  chk_vint_hold: assert property (!vint_clear_n |=> !vint)
    else $error("interrupt not held cleared");
  chk_vint_set: assert property ($rose(vint) |->
    $past(vline_r) == 10'($past(vdisp_end) + 10'h001) && !$past(vint_disable))
    else $error("interrupt set at wrong line or while disabled");
  chk_cursor_off: assert property (
    cursor_first_row_r[crt_vert_pkg::BIT_TEXT_CURSOR_DISABLE] || cursor_start > cursor_end
    |-> !cursor_raw)
    else $error("cursor shown while suppressed");
  chk_cursor_delay: assert property (char_clk_en && cursor_delay == 2'h0 ##1
    cursor_delay == 2'h0 |=> text_cursor == $past(cursor_raw, 2))
    else $error("zero skew cursor mismatch");
  chk_underline_row: assert property (underline |->
    $past(row_scan_r) == 5'($past(underline_and_addr_mode_r[4:0]) + 5'h01))
    else $error("underline on wrong row");
  chk_refresh_count: assert property (!refresh_five_line_r |-> refresh_seen_r <= 3'h3)
    else $error("too many refresh cycles");
  chk_row_wrap: assert property (hretrace_start && row_scan_r == max_scan |=>
    row_scan_r == 5'h00)
    else $error("row scan did not clear at max");
  chk_origin_load: assert property (hretrace_start && frame_wrap |=>
    mem_addr == {$past(display_origin_hi_r), $past(display_origin_lo_r)})
    else $error("start address not loaded");

  cov_vsync_pulse: cover property ($rose(vsync) ##[1:1000] $fell(vsync));
  cov_vint_service: cover property ($rose(vint) ##[1:1000] !vint_clear_n);
  cov_cursor_shown: cover property ($rose(text_cursor));
  cov_refresh_five: cover property (refresh_five && refresh_seen_r == 3'h5);

endmodule : crt_cursor_vertical_timing

`default_nettype wire

//--- crt_vert_pkg.sv
// package: register map, fields and carrier types for the cursor and vertical timing block
package crt_vert_pkg;

  // register indices on the indexed data port
  localparam logic [7:0] IDX_CURSOR_FIRST_ROW = 8'h0a;
  localparam logic [7:0] IDX_CURSOR_LAST_ROW = 8'h0b;
  localparam logic [7:0] IDX_DISPLAY_ORIGIN_HI = 8'h0c;
  localparam logic [7:0] IDX_DISPLAY_ORIGIN_LO = 8'h0d;
  localparam logic [7:0] IDX_CURSOR_ADDR_HI = 8'h0e;
  localparam logic [7:0] IDX_CURSOR_ADDR_LO = 8'h0f;
  localparam logic [7:0] IDX_VSYNC_BEGIN = 8'h10;
  localparam logic [7:0] IDX_VSYNC_END_CONTROL = 8'h11;
  localparam logic [7:0] IDX_VDISPLAY_LAST_LINE = 8'h12;
  localparam logic [7:0] IDX_ROW_PITCH = 8'h13;
  localparam logic [7:0] IDX_UNDERLINE_AND_ADDR_MODE = 8'h14;
  localparam logic [7:0] IDX_VBLANK_BEGIN = 8'h15;
  localparam logic [7:0] IDX_VBLANK_FINISH = 8'h16;

  // writable bit masks; reserved bits read zero
  localparam logic [7:0] MASK_CURSOR_FIRST_ROW = 8'h3f;
  localparam logic [7:0] MASK_CURSOR_LAST_ROW = 8'h7f;
  localparam logic [7:0] MASK_UNDERLINE_AND_ADDR_MODE = 8'h7f;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;

  // field positions
  localparam int ROW_FIELD_MSB = 4;
  localparam int BIT_TEXT_CURSOR_DISABLE = 5;
  localparam int BIT_CURSOR_DELAY_LSB = 5;
  localparam int BIT_VINT_CLEAR_N = 4;
  localparam int BIT_VINT_DISABLE = 5;
  localparam int BIT_REFRESH_FIVE = 6;
  localparam int BIT_TIMING_WRITE_PROTECT = 7;
  localparam int BIT_ADDR_STEP_FOUR = 5;
  localparam int BIT_DOUBLEWORD_ADDRESSING = 6;
  // overflow register positions
  localparam int OVF_VT8 = 0;
  localparam int OVF_VDE8 = 1;
  localparam int OVF_VRS8 = 2;
  localparam int OVF_SVB8 = 3;
  localparam int OVF_SPLIT_LINE_BIT8 = 4;
  localparam int OVF_VT9 = 5;
  localparam int OVF_VDE9 = 6;
  localparam int OVF_VRS9 = 7;
  localparam int MSL_SVB9 = 5;

  localparam logic [2:0] REFRESH_THREE = 3'h3;
  localparam logic [2:0] REFRESH_FIVE = 3'h5;

  // timing registers held outside this block
  typedef struct packed {
    logic [7:0] vtotal_lo;
    logic [7:0] overflow;
    logic [7:0] max_scan_line;
  } ext_timing_type;

  // mode bits held outside this block
  typedef struct packed {
    logic count_by_two;
    logic enhanced;
  } ext_mode_type;

endpackage : crt_vert_pkg

//--- scan_source.sv
// line timing source standing in for the horizontal side of the controller
`timescale 1ns/1ps
`default_nettype none
module scan_source #(
  parameter int LINE_LEN = 24,
  parameter int DISP_LEN = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic char_clk_en,
  output logic hdisplay,
  output logic hretrace_start
);
  int pos_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) pos_r <= 0;
    else pos_r <= (pos_r == LINE_LEN - 1) ? 0 : pos_r + 1;
  end
  assign char_clk_en = rst_n;
  assign hdisplay = (pos_r < DISP_LEN);
  // one retrace pulse per scan line
  assign hretrace_start = (pos_r == DISP_LEN);
endmodule : scan_source
`default_nettype wire

//--- testbench.sv
// self-checking bench for the cursor and vertical timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, rst_n, index_wr, data_wr, data_rd, char_clk_en, hretrace_start, hdisplay;
  logic [7:0] wdata, rdata, fg, bg, v;
  crt_vert_pkg::ext_timing_type ext_timing;
  crt_vert_pkg::ext_mode_type ext_mode;
  logic wp, vsync, vblank, vint, text_cursor, underline, refresh_req, step4, dword;
  logic [15:0] mem_addr, ma_exp, mb_exp;
  logic [7:0] exp_q[$];
  int bad_count, check_count, cycles, vs, vb, ul, rf, ma, mb, tc;
  crt_cursor_vertical_timing crt_cursor_vertical_timing_i (.core_clk(core_clk), .rst_n(rst_n),
    .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata),
    .char_clk_en(char_clk_en), .hretrace_start(hretrace_start), .hdisplay(hdisplay),
    .ext_timing(ext_timing), .ext_mode(ext_mode), .rdata(rdata), .timing_write_protect(wp),
    .vsync(vsync), .vblank(vblank), .vint(vint), .text_cursor(text_cursor),
    .underline(underline), .mem_addr(mem_addr), .refresh_req(refresh_req), .hw_cursor_fg(fg),
    .hw_cursor_bg(bg), .addr_step_four(step4), .doubleword_addressing(dword));
  scan_source scan_source_i (.core_clk(core_clk), .rst_n(rst_n), .char_clk_en(char_clk_en),
    .hdisplay(hdisplay), .hretrace_start(hretrace_start));
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic complete_run();
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge core_clk) #1 index_wr = 1; wdata = idx;
    @(posedge core_clk) #1 index_wr = 0; data_wr = 1; wdata = val;
    @(posedge core_clk) #1 data_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge core_clk) #1 index_wr = 1; wdata = idx;
    @(posedge core_clk) #1 index_wr = 0; data_rd = 1;
    exp_q.push_back(exp);
    @(posedge core_clk) #1 data_rd = 0;
  endtask : rd
  // counts over n line pulses the lines seen with vsync, vblank, underline high
  // and with the expected line addresses; tc counts every cycle with the cursor shown
  task automatic lines(input int n);
    vs = 0;
    vb = 0;
    ul = 0;
    ma = 0;
    mb = 0;
    tc = 0;
    while (n > 0) begin
      @(posedge core_clk) #2;
      tc += text_cursor;
      if (hretrace_start) begin
        n--;
        vs += vsync;
        vb += vblank;
        ul += underline;
        ma += (mem_addr === ma_exp);
        mb += (mem_addr === mb_exp);
      end
    end
  endtask : lines
  task automatic refresh_count();
    rf = 0;
    @(posedge core_clk iff hretrace_start);
    repeat (24) @(posedge core_clk) rf += refresh_req;
  endtask : refresh_count
  function automatic logic [7:0] mask(input logic [7:0] idx);
    case (idx)
      crt_vert_pkg::IDX_CURSOR_FIRST_ROW: return crt_vert_pkg::MASK_CURSOR_FIRST_ROW;
      crt_vert_pkg::IDX_CURSOR_LAST_ROW: return crt_vert_pkg::MASK_CURSOR_LAST_ROW;
      crt_vert_pkg::IDX_UNDERLINE_AND_ADDR_MODE: return crt_vert_pkg::MASK_UNDERLINE_AND_ADDR_MODE;
      default: return crt_vert_pkg::MASK_FULL;
    endcase
  endfunction : mask
  // read results land one edge after the read strobe
  always @(posedge core_clk) if (data_rd === 1'b1) begin
    #2 check(rdata, exp_q.pop_front());
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    {index_wr, data_wr, data_rd, wdata} = '0;
    ext_mode = '0;
    ext_timing = '{vtotal_lo: 8'h28, overflow: 8'h00, max_scan_line: 8'h03};
    rst_n = 0;
    void'($urandom(32'h262d));
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1;
    repeat (3) @(posedge core_clk);
    for (int i = 8'h0a; i <= 8'h16; i++) rd(8'(i), 8'h00);
    for (int i = 8'h0a; i <= 8'h16; i++) begin
      v = 8'($urandom);
      wr(8'(i), v);
      rd(8'(i), v & mask(8'(i)));
    end
    rd(8'h20, 8'h00);
    wr(8'h11, 8'h80);
    // control outputs follow the register one edge later
    @(posedge core_clk) #1;
    check(wp, 1'b1);
    wr(8'h14, 8'h61);
    @(posedge core_clk) #1;
    check({step4, dword}, 2'b11);
    ext_mode.enhanced = 1;
    wr(8'h0e, 8'ha5);
    wr(8'h0f, 8'h5a);
    repeat (2) @(posedge core_clk);
    check({fg, bg}, 16'ha55a);
    wr(8'h0c, 8'h12);
    wr(8'h0d, 8'h34);
    wr(8'h13, 8'h05);
    wr(8'h0e, 8'h12);
    wr(8'h0f, 8'h35);
    wr(8'h0a, 8'h00);
    wr(8'h0b, 8'h02);
    // sampled at line end: three four-character steps past the row start
    ma_exp = 16'h1237;
    // doubleword rows: start plus eight times the pitch of 5, plus the same three steps
    mb_exp = 16'h125f;
    wr(8'h12, 8'd20);
    wr(8'h10, 8'd30);
    wr(8'h11, 8'h11);
    wr(8'h15, 8'd24);
    wr(8'h16, 8'd28);
    check(wp, 1'b0);
    lines(42);
    lines(42);
    check(vs, 3);
    check(vb, 3);
    check(ul, 10);
    check(ma, 4);
    check(mb, 4);
    check(tc, 8);
    check(vint, 1'b1);
    wr(8'h11, 8'h01);
    repeat (2) @(posedge core_clk);
    check(vint, 1'b0);
    wr(8'h11, 8'h11);
    lines(43);
    check(vint, 1'b1);
    wr(8'h0a, 8'h20);
    wr(8'h11, 8'h21);
    wr(8'h11, 8'h31);
    lines(43);
    check(vint, 1'b0);
    check(tc, 0);
    refresh_count();
    check(rf, 3);
    wr(8'h11, 8'h71);
    refresh_count();
    check(rf, 5);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
